//--- design/csl_pkg.sv
// Package of constants for the configuration strap latch block
package csl_pkg;
  // ------------------------------------------------------------
  // Strap widths and encodings
  // ------------------------------------------------------------
  localparam int unsigned NUM_PORTS   = 7;
  localparam int unsigned MODE_W      = 3;
  localparam int unsigned COUNT_W     = 3;
  // Device-mode strap codes, one per resistor setting
  localparam logic [2:0] MODE_SPEED_SMB_OFF  = 3'h0;
  localparam logic [2:0] MODE_SPEED_SMB_SLV  = 3'h1;
  localparam logic [2:0] MODE_RSVD_3         = 3'h2;
  localparam logic [2:0] MODE_RSVD_4         = 3'h3;
  localparam logic [2:0] MODE_CHARGE_IND     = 3'h4;
  localparam logic [2:0] MODE_RSVD_6         = 3'h5;

  typedef enum logic [1:0] {
    CSL_IND_NONE,
    CSL_IND_SPEED,
    CSL_IND_CHARGE
  } csl_ind_type;

  // ------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_STRAP_STATUS = 12'h000;
  localparam logic [11:0] ADDR_PORT_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_CONTROL      = 12'h008;
  localparam int unsigned ADDR_W            = 12;
  // Strap status fields
  localparam int unsigned SS_MODE_LSB       = 0;
  localparam int unsigned SS_NONREM_LSB     = 4;
  localparam int unsigned SS_CHARGE_LSB     = 8;
  localparam int unsigned SS_VALID_BIT      = 31;
  // Port status fields
  localparam int unsigned PS_POS_LSB        = 0;
  localparam int unsigned PS_NEG_LSB        = 8;
  localparam int unsigned PS_DIS_LSB        = 16;
  // Control fields
  localparam int unsigned CTL_IND_EN_BIT    = 0;
  localparam logic        CTL_IND_EN_RESET  = 1'b1;
endpackage

//--- design/csl_strap_latch.sv
// Configuration strap latch with AHB-Lite status and control registers
//
// Summary of operation
// - Sample all straps at power-on reset and at external reset rising edge.
// - Captured strap levels become the default setting of each feature.
// - Strap pins read only in reset; afterwards they carry run-time outputs.
// - Operating mode comes from the latched device-mode strap.
// - Each port 7..1 disable combines its positive and negative line straps.
// - Non-removable port count comes from its latched strap.
// - Charging-enabled port count comes from its latched strap.
// - Port disabled only when both straps read 1; fast side follows.
// - Mode codes: speed+bus off, speed+bus slave, charging; others reserved.
// - Speed indicator floats unconnected, 0 for slow, 1 for fast link.
`timescale 1ns/1ps

module csl_strap_latch #(
  parameter int unsigned NUM_PORTS = csl_pkg::NUM_PORTS,
  parameter int unsigned MODE_W    = csl_pkg::MODE_W,
  parameter int unsigned COUNT_W   = csl_pkg::COUNT_W
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 reset_n_ext,
  // Strap pins
  input  wire logic [MODE_W-1:0]    device_mode_strap,
  input  wire logic [NUM_PORTS:1]   port_pos_line_disable_strap,
  input  wire logic [NUM_PORTS:1]   port_neg_line_disable_strap,
  input  wire logic [COUNT_W-1:0]   nonremovable_count_strap,
  input  wire logic [COUNT_W-1:0]   charging_port_count_strap,
  // Port state from the hub core
  input  wire logic [NUM_PORTS:1]   port_connected,
  input  wire logic [NUM_PORTS:1]   port_superspeed,
  input  wire logic [NUM_PORTS:1]   port_charge_handshake_done,
  // Run-time functions of the shared pins
  output logic [NUM_PORTS:1]        port_speed_indicator,
  output logic [NUM_PORTS:1]        port_speed_indicator_oe,
  output logic [NUM_PORTS:1]        charging_indicator,
  output logic [NUM_PORTS:1]        charging_indicator_oe,
  // Configuration presented to the hub core
  output logic [NUM_PORTS:1]        port_disable,
  output logic [NUM_PORTS:1]        port_nonremovable,
  output logic [NUM_PORTS:1]        port_charging_enable,
  output logic                      bus_slave_enable,
  output logic                      config_valid,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp
);

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  function automatic csl_pkg::csl_ind_type mode_ind(
    input logic [MODE_W-1:0] m);
    csl_pkg::csl_ind_type r;
    r = csl_pkg::CSL_IND_NONE;
    case (m)
      csl_pkg::MODE_SPEED_SMB_OFF: r = csl_pkg::CSL_IND_SPEED;
      csl_pkg::MODE_SPEED_SMB_SLV: r = csl_pkg::CSL_IND_SPEED;
      csl_pkg::MODE_CHARGE_IND:    r = csl_pkg::CSL_IND_CHARGE;
      default:                     r = csl_pkg::CSL_IND_NONE;
    endcase
    return r;
  endfunction

  // Ports 1..count selected by a count strap
  function automatic logic [NUM_PORTS:1] count_mask(
    input logic [COUNT_W-1:0] c);
    logic [NUM_PORTS:1] r;
    r = '0;
    for (int i = 1; i <= NUM_PORTS; i++) begin
      r[i] = (32'(i) <= 32'(c));
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Latched strap state
  // ------------------------------------------------------------
  logic [MODE_W-1:0]  mode_reg,   mode_next;
  logic [NUM_PORTS:1] pos_reg,    pos_next;
  logic [NUM_PORTS:1] neg_reg,    neg_next;
  logic [COUNT_W-1:0] nonrem_reg, nonrem_next;
  logic [COUNT_W-1:0] charge_reg, charge_next;
  logic               pending_reg, pending_next;
  logic               ext_prev_reg, ext_prev_next;
  logic               valid_reg,  valid_next;
  logic               capture;

  always_comb begin
    // POR capture waits for the first edge with the external reset high
    capture = (pending_reg || !ext_prev_reg) && reset_n_ext;
    mode_next     = mode_reg;
    pos_next      = pos_reg;
    neg_next      = neg_reg;
    nonrem_next   = nonrem_reg;
    charge_next   = charge_reg;
    pending_next  = pending_reg && !reset_n_ext;
    ext_prev_next = reset_n_ext;
    valid_next    = valid_reg && reset_n_ext;
    if (capture) begin
      mode_next   = device_mode_strap;
      pos_next    = port_pos_line_disable_strap;
      neg_next    = port_neg_line_disable_strap;
      nonrem_next = nonremovable_count_strap;
      charge_next = charging_port_count_strap;
      valid_next  = 1'b1;
    end
    // Otherwise held: no other path writes them
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg     <= '0;
      pos_reg      <= '0;
      neg_reg      <= '0;
      nonrem_reg   <= '0;
      charge_reg   <= '0;
      pending_reg  <= 1'b1;
      ext_prev_reg <= 1'b0;
      valid_reg    <= 1'b0;
    end else begin
      mode_reg     <= mode_next;
      pos_reg      <= pos_next;
      neg_reg      <= neg_next;
      nonrem_reg   <= nonrem_next;
      charge_reg   <= charge_next;
      pending_reg  <= pending_next;
      ext_prev_reg <= ext_prev_next;
      valid_reg    <= valid_next;
    end
  end

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [31:0]                 hrdata_reg, hrdata_next;
  logic                        wr_pend_reg, wr_pend_next;
  logic [csl_pkg::ADDR_W-1:0]  wr_addr_reg, wr_addr_next;
  logic                        ind_en_reg, ind_en_next;
  logic                        access;
  logic [31:0]                 rd_word;

  always_comb begin
    access = hsel && htrans[1] && hready;
    rd_word = '0;
    case (haddr[csl_pkg::ADDR_W-1:0])
      csl_pkg::ADDR_STRAP_STATUS: begin
        rd_word[csl_pkg::SS_MODE_LSB +: MODE_W]    = mode_reg;
        rd_word[csl_pkg::SS_NONREM_LSB +: COUNT_W] = nonrem_reg;
        rd_word[csl_pkg::SS_CHARGE_LSB +: COUNT_W] = charge_reg;
        rd_word[csl_pkg::SS_VALID_BIT]             = valid_reg;
      end
      csl_pkg::ADDR_PORT_STATUS: begin
        rd_word[csl_pkg::PS_POS_LSB +: NUM_PORTS] = pos_reg;
        rd_word[csl_pkg::PS_NEG_LSB +: NUM_PORTS] = neg_reg;
        rd_word[csl_pkg::PS_DIS_LSB +: NUM_PORTS] = pos_reg & neg_reg;
      end
      csl_pkg::ADDR_CONTROL:
        rd_word[csl_pkg::CTL_IND_EN_BIT] = ind_en_reg;
      default: rd_word = '0;
    endcase
    if (|haddr[31:csl_pkg::ADDR_W]) begin
      rd_word = '0;
    end
    hrdata_next  = (access && !hwrite) ? rd_word : hrdata_reg;
    wr_pend_next = access && hwrite && !(|haddr[31:csl_pkg::ADDR_W]);
    wr_addr_next = access ? haddr[csl_pkg::ADDR_W-1:0] : wr_addr_reg;
    ind_en_next  = ind_en_reg;
    if (wr_pend_reg && wr_addr_reg == csl_pkg::ADDR_CONTROL) begin
      ind_en_next = hwdata[csl_pkg::CTL_IND_EN_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata_reg  <= '0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      ind_en_reg  <= csl_pkg::CTL_IND_EN_RESET;
    end else begin
      hrdata_reg  <= hrdata_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      ind_en_reg  <= ind_en_next;
    end
  end

  // ------------------------------------------------------------
  // Configuration and shared pin outputs
  // ------------------------------------------------------------
  csl_pkg::csl_ind_type ind_mode;
  logic [NUM_PORTS:1]   dis_next, nonrem_mask_next, charge_mask_next;
  logic [NUM_PORTS:1]   spd_next, spd_oe_next, chg_next, chg_oe_next;
  logic                 slave_next;
  logic [NUM_PORTS:1]   dis_reg, nonrem_mask_reg, charge_mask_reg;
  logic [NUM_PORTS:1]   spd_reg, spd_oe_reg, chg_reg, chg_oe_reg;
  logic                 slave_reg;
  logic                 run;

  always_comb begin
    ind_mode = mode_ind(mode_reg);
    // Pins stay released while in reset so straps read cleanly
    run = valid_reg && reset_n_ext && ind_en_reg;
    dis_next         = pos_reg & neg_reg;
    nonrem_mask_next = count_mask(nonrem_reg) & ~dis_next;
    charge_mask_next = count_mask(charge_reg) & ~dis_next;
    slave_next = valid_reg && (mode_reg == csl_pkg::MODE_SPEED_SMB_SLV);
    spd_next    = '0;
    spd_oe_next = '0;
    chg_next    = '0;
    chg_oe_next = '0;
    if (run && ind_mode == csl_pkg::CSL_IND_SPEED) begin
      spd_oe_next = port_connected & ~dis_next;
      spd_next    = port_superspeed & spd_oe_next;
    end
    if (run && ind_mode == csl_pkg::CSL_IND_CHARGE) begin
      chg_oe_next = charge_mask_next;
      chg_next    = ~port_charge_handshake_done & chg_oe_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dis_reg         <= '0;
      nonrem_mask_reg <= '0;
      charge_mask_reg <= '0;
      spd_reg         <= '0;
      spd_oe_reg      <= '0;
      chg_reg         <= '0;
      chg_oe_reg      <= '0;
      slave_reg       <= 1'b0;
    end else begin
      dis_reg         <= dis_next;
      nonrem_mask_reg <= nonrem_mask_next;
      charge_mask_reg <= charge_mask_next;
      spd_reg         <= spd_next;
      spd_oe_reg      <= spd_oe_next;
      chg_reg         <= chg_next;
      chg_oe_reg      <= chg_oe_next;
      slave_reg       <= slave_next;
    end
  end

  // Bus answer is always ready and OKAY, both held in flops
  logic hready_reg;
  logic hresp_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end else begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end
  end

  assign port_speed_indicator    = spd_reg;
  assign port_speed_indicator_oe = spd_oe_reg;
  assign charging_indicator      = chg_reg;
  assign charging_indicator_oe   = chg_oe_reg;
  assign port_disable            = dis_reg;
  assign port_nonremovable       = nonrem_mask_reg;
  assign port_charging_enable    = charge_mask_reg;
  assign bus_slave_enable        = slave_reg;
  assign config_valid            = valid_reg;
  assign hrdata                  = hrdata_reg;
  assign hreadyout               = hready_reg;
  assign hresp                   = hresp_reg;

endmodule // csl_strap_latch

//--- bench/csl_strap_board.sv
// Board strap resistors feeding fixed levels into the strap pins
`timescale 1ns/1ps

module csl_strap_board (
  input  wire logic [2:0] mode_level,
  input  wire logic [7:1] pos_level,
  input  wire logic [7:1] neg_level,
  input  wire logic [2:0] nonrem_level,
  input  wire logic [2:0] charge_level,
  output wire logic [2:0] device_mode_strap,
  output wire logic [7:1] port_pos_line_disable_strap,
  output wire logic [7:1] port_neg_line_disable_strap,
  output wire logic [2:0] nonremovable_count_strap,
  output wire logic [2:0] charging_port_count_strap
);
  // Resistors always drive; a level present at capture is what is seen
  assign device_mode_strap           = mode_level;
  assign port_pos_line_disable_strap = pos_level;
  assign port_neg_line_disable_strap = neg_level;
  assign nonremovable_count_strap    = nonrem_level;
  assign charging_port_count_strap   = charge_level;
endmodule // csl_strap_board

//--- bench/csl_strap_latch_monitor.sv
// Checker of strap capture, derived configuration and indicator pins
`timescale 1ns/1ps

module csl_strap_latch_monitor #(
  parameter int unsigned NUM_PORTS = 7
) (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire logic                 reset_n_ext,
  input wire logic [2:0]           device_mode_strap,
  input wire logic [NUM_PORTS:1]   port_pos_line_disable_strap,
  input wire logic [NUM_PORTS:1]   port_neg_line_disable_strap,
  input wire logic [2:0]           nonremovable_count_strap,
  input wire logic [2:0]           charging_port_count_strap,
  input wire logic [NUM_PORTS:1]   port_connected,
  input wire logic [NUM_PORTS:1]   port_superspeed,
  input wire logic [NUM_PORTS:1]   port_speed_indicator,
  input wire logic [NUM_PORTS:1]   port_speed_indicator_oe,
  input wire logic [NUM_PORTS:1]   charging_indicator_oe,
  input wire logic [NUM_PORTS:1]   port_disable,
  input wire logic [NUM_PORTS:1]   port_nonremovable,
  input wire logic [NUM_PORTS:1]   port_charging_enable,
  input wire logic                 bus_slave_enable,
  input wire logic                 config_valid
);
  function automatic logic [NUM_PORTS:1] msk(input logic [2:0] c);
    msk = '0;
    for (int i = 1; i <= NUM_PORTS; i++)
      msk[i] = (i <= c);
  endfunction
  wire logic [NUM_PORTS:1] both = port_pos_line_disable_strap &
                                  port_neg_line_disable_strap;
  wire logic [NUM_PORTS:1] nr_m = msk(nonremovable_count_strap) & ~both;
  wire logic [NUM_PORTS:1] ch_m = msk(charging_port_count_strap) & ~both;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_vlow; !reset_n_ext |=> !config_valid; endproperty
  a_vlow: assert property (p_vlow) else $error("valid in ext reset");
  property p_vrise; $rose(reset_n_ext) |=> config_valid; endproperty
  a_vrise: assert property (p_vrise) else $error("no capture");
  property p_dis; $rose(reset_n_ext) |=> ##1 port_disable == $past(both, 2);
  endproperty
  a_dis: assert property (p_dis) else $error("port disable wrong");
  property p_mode; $rose(reset_n_ext) |=> ##1 bus_slave_enable ==
    ($past(device_mode_strap, 2) == csl_pkg::MODE_SPEED_SMB_SLV); endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_nrm; $rose(reset_n_ext) |=> ##1 port_nonremovable ==
    $past(nr_m, 2); endproperty
  a_nrm: assert property (p_nrm) else $error("nonremovable mask wrong");
  property p_chg; $rose(reset_n_ext) |=> ##1 port_charging_enable ==
    $past(ch_m, 2); endproperty
  a_chg: assert property (p_chg) else $error("charging mask wrong");
  property p_hold; config_valid && $past(config_valid) &&
    $past(config_valid, 2)
    |-> $stable(port_disable) && $stable(port_nonremovable) &&
    $stable(bus_slave_enable); endproperty
  a_hold: assert property (p_hold) else $error("config changed");
  property p_spd; (port_speed_indicator_oe & ~$past(port_connected)) == '0 &&
    ((port_speed_indicator ^ $past(port_superspeed)) &
    port_speed_indicator_oe) == '0; endproperty
  a_spd: assert property (p_spd) else $error("speed pin wrong");
  property p_rel; !reset_n_ext |=>
    (port_speed_indicator_oe | charging_indicator_oe) == '0; endproperty
  a_rel: assert property (p_rel) else $error("pin driven in reset");
endmodule // csl_strap_latch_monitor

bind csl_strap_latch csl_strap_latch_monitor #(.NUM_PORTS(NUM_PORTS))
  csl_strap_latch_monitor_inst (.clock(clock), .rst(rst),
  .reset_n_ext(reset_n_ext), .device_mode_strap(device_mode_strap),
  .port_pos_line_disable_strap(port_pos_line_disable_strap),
  .port_neg_line_disable_strap(port_neg_line_disable_strap),
  .nonremovable_count_strap(nonremovable_count_strap),
  .charging_port_count_strap(charging_port_count_strap),
  .port_connected(port_connected), .port_superspeed(port_superspeed),
  .port_speed_indicator(port_speed_indicator),
  .port_speed_indicator_oe(port_speed_indicator_oe),
  .charging_indicator_oe(charging_indicator_oe),
  .port_disable(port_disable), .port_nonremovable(port_nonremovable),
  .port_charging_enable(port_charging_enable),
  .bus_slave_enable(bus_slave_enable), .config_valid(config_valid));

//--- bench/tb_config_strap_latch.sv
// Self-checking bench of the strap latch
`timescale 1ns/1ps

module tb_config_strap_latch;
  typedef struct packed {
    logic [2:0] md; logic [7:1] p, n; logic [2:0] nr, ch;
    logic [7:1] dis, enr, ech, eso, eco; logic slv;
  } csl_row_type;
  logic clock = 1'b0, rst = 1'b1, reset_n_ext = 1'b1, hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] lv_md = 3'h0, lv_nr = 3'h0, lv_ch = 3'h0, hsize = 3'h2;
  logic [7:1] lv_p = 7'h0C, lv_n = 7'h0A, conn = 7'h0F, ss = 7'h05;
  logic [7:1] hs = 7'h01;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, ex;
  wire logic [2:0] s_md, s_nr, s_ch;
  wire logic [7:1] s_p, s_n, spd, spd_oe, chi, chi_oe, dis, nrm, che;
  wire logic slv, vld, hready, hresp;
  wire logic [31:0] hrdata;
  int num_errors = 0, cmp_count = 0;
  csl_row_type rows [6] = '{
    '{3'h0, 7'h7F, 7'h01, 3'h7, 3'h0, 7'h01, 7'h7E, 7'h00, 7'h0E, 7'h00, 1'b0},
    '{3'h4, 7'h00, 7'h7F, 3'h3, 3'h2, 7'h00, 7'h07, 7'h03, 7'h00, 7'h03, 1'b0},
    '{3'h5, 7'h40, 7'h40, 3'h0, 3'h7, 7'h40, 7'h00, 7'h3F, 7'h00, 7'h00, 1'b0},
    '{3'h2, 7'h7F, 7'h7F, 3'h7, 3'h7, 7'h7F, 7'h00, 7'h00, 7'h00, 7'h00, 1'b0},
    '{3'h3, 7'h00, 7'h00, 3'h0, 3'h0, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 1'b0},
    '{3'h1, 7'h55, 7'h33, 3'h1, 3'h7, 7'h11, 7'h00, 7'h6E, 7'h0E, 7'h00, 1'b1}};
`define check_eq(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end

  always #5 clock = ~clock;
  csl_strap_board csl_strap_board_inst (.mode_level(lv_md), .pos_level(lv_p),
    .neg_level(lv_n), .nonrem_level(lv_nr), .charge_level(lv_ch),
    .device_mode_strap(s_md), .port_pos_line_disable_strap(s_p),
    .port_neg_line_disable_strap(s_n), .nonremovable_count_strap(s_nr),
    .charging_port_count_strap(s_ch));
  csl_strap_latch csl_strap_latch_inst (.clock(clock), .rst(rst),
    .reset_n_ext(reset_n_ext), .device_mode_strap(s_md),
    .port_pos_line_disable_strap(s_p), .port_neg_line_disable_strap(s_n),
    .nonremovable_count_strap(s_nr), .charging_port_count_strap(s_ch),
    .port_connected(conn), .port_superspeed(ss),
    .port_charge_handshake_done(hs), .port_speed_indicator(spd),
    .port_speed_indicator_oe(spd_oe), .charging_indicator(chi),
    .charging_indicator_oe(chi_oe), .port_disable(dis),
    .port_nonremovable(nrm), .port_charging_enable(che),
    .bus_slave_enable(slv), .config_valid(vld), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp));

  task automatic summarize;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge clock);
    while (hready !== 1'b1) begin
      if (++k > 20) begin num_errors++; summarize(); end
      @(posedge clock);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, wd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwrite <= 1'b0; hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic relatch(input csl_row_type r);
    lv_md <= r.md; lv_p <= r.p; lv_n <= r.n; lv_nr <= r.nr; lv_ch <= r.ch;
    reset_n_ext <= 1'b0;
    tick(2);
    reset_n_ext <= 1'b1;
    tick(3);
  endtask

  initial begin
    #200000 num_errors++;
    summarize();
  end
  initial begin
    tick(16);
    `check_eq("vld_in_rst", 1'b0, vld)
    `check_eq("hready_in_rst", 1'b1, hready)
    rst <= 1'b0;
    tick(3);
    `check_eq("por_dis", 7'h08, dis)
    `check_eq("por_vld", 1'b1, vld)
    ahb(1'b0, 32'h008, 32'h0);
    `check_eq("ctl_reset", 32'h1, rd)
    for (int i = 0; i < 6; i++) begin
      relatch(rows[i]);
      `check_eq("dis", rows[i].dis, dis)
      `check_eq("nonrem", rows[i].enr, nrm)
      `check_eq("charge", rows[i].ech, che)
      `check_eq("slave", rows[i].slv, slv)
      `check_eq("spd_oe", rows[i].eso, spd_oe)
      `check_eq("spd", ss & rows[i].eso, spd & spd_oe)
      `check_eq("chg_oe", rows[i].eco, chi_oe)
      `check_eq("chg", ~hs & rows[i].eco, chi & chi_oe)
      ahb(1'b0, 32'h000, 32'h0);
      ex = {1'b1, 20'h0, rows[i].ch, 1'b0, rows[i].nr, 1'b0, rows[i].md};
      `check_eq("strap_status", ex, rd)
      ahb(1'b0, 32'h004, 32'h0);
      ex = {9'h0, rows[i].dis, 1'b0, rows[i].n, 1'b0, rows[i].p};
      `check_eq("port_status", ex, rd)
    end
    lv_p <= 7'h7F; lv_n <= 7'h7F; lv_md <= 3'h4;
    tick(4);
    `check_eq("hold_dis", 7'h11, dis)
    `check_eq("hold_slave", 1'b1, slv)
    ahb(1'b1, 32'h008, 32'h0);
    tick(2);
    `check_eq("ind_off", 7'h00, spd_oe)
    ahb(1'b0, 32'h008, 32'h0);
    `check_eq("ctl_rw", 32'h0, rd)
    ahb(1'b1, 32'h008, 32'h1);
    ahb(1'b1, 32'h00C, 32'hFFFFFFFF);
    ahb(1'b0, 32'h00C, 32'h0);
    `check_eq("unmapped", 32'h0, rd)
    ahb(1'b1, 32'h000, 32'h0);
    ahb(1'b0, 32'h000, 32'h0);
    `check_eq("ro_status", 32'h80000711, rd)
    `check_eq("ind_on", 7'h0E, spd_oe)
    `check_eq("hresp", 1'b0, hresp)
    // Link state now moves under a settled configuration
    conn <= 7'h7F;
    ss <= 7'h22;
    tick(2);
    `check_eq("spd_oe_conn", 7'h6E, spd_oe)
    `check_eq("spd_conn", 7'h22, spd)
    rst <= 1'b1;
    tick(2);
    `check_eq("rst_vld", 1'b0, vld)
    `check_eq("rst_dis", 7'h00, dis)
    rst <= 1'b0;
    tick(3);
    `check_eq("por2_dis", 7'h7F, dis)
    `check_eq("por2_slave", 1'b0, slv)
    summarize();
  end
endmodule // tb_config_strap_latch
